// File: shared/hpif_cfg.svh
// constants of the parallel host port block
`ifndef HPIF_CFG_SVH
`define HPIF_CFG_SVH
`define HPIF_SEL_CTRL 2'h0
`define HPIF_SEL_DATA_INC 2'h1
`define HPIF_SEL_ADDR 2'h2
`define HPIF_SEL_DATA 2'h3
`define HPIF_CTRL_RST 16'h0000
`define HPIF_CTRL_HOSTIRQ_BIT 3
`define HPIF_CTRL_DEVIRQ_BIT 2
`define HPIF_ADDR_RST 16'h0000
`define HPIF_IRQ_RST 1'h1
`endif

// File: shared/hpif_pkg.sv
// types of the parallel host port block
package hpif_pkg;
    typedef enum logic [1:0] {
        HPIF_IDLE,
        HPIF_MEM,
        HPIF_DONE
    } hpif_state_t;
endpackage

// File: src/hpif_strobe.sv
// strobe combiner and edge detector for the host port
module hpif_strobe (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic port_select_n_i,
    input wire logic host_strobe_a_n_i,
    input wire logic host_strobe_b_n_i,
    output logic strobe_start_o,
    output logic strobe_end_o
);
    logic act_r;
    logic act_nxt;

    always_comb begin
        // strobes count only while the port is selected
        act_nxt = ~port_select_n_i & ~(host_strobe_a_n_i & host_strobe_b_n_i)
                  & (host_strobe_a_n_i ^ host_strobe_b_n_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            act_r <= 1'b0;
        end else begin
            act_r <= act_nxt;
        end
    end

    assign strobe_start_o = act_nxt & ~act_r;
    assign strobe_end_o = ~act_nxt & act_r;
endmodule

// File: src/hpif_port.sv
// pin-level logic of the parallel host port
`include "hpif_cfg.svh"

// Notes on behaviour
// - two select inputs choose control, address or data register for each access.
// - byte flag marks first or second byte; ignored in wide mode.
// - host strobes time each transfer; device transfers under their control.
// - address strobe latches the address from the byte bus into address register.
// - direction input chooses read or write; bus driven or received accordingly.
// - ready only when next transfer can be taken; floats under output-disable.
// - interrupt output driven high while the device is held in reset.
// - port disabled lets interrupt pin carry timer 1; no interrupt in wide mode.
// - enable strap sampled at reset release; port enabled only if strap high.
// - once disabled, enable strap ignored until the next device reset.
// - wide strap high gives non-multiplexed mode with 16 address and data lines.
// - no host or device interrupts in non-multiplexed mode.
// - control and address registers absent in non-multiplexed mode.
// - wide strap defaults low by internal pull, so byte mode by default.
// - byte bus floats unless outputting, and always under output-disable; general I/O in wide mode.
// - bus holders keep last level; off at reset, switched by holder bit.
// - control input pullups only while enable strap low; selects also in wide mode.
// - output-disable condition floats every output driver.
module hpif_port
    import hpif_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic port_enable_strap_i,
    input wire logic wide_mode_strap_i,
    input wire logic test_reset_i,
    input wire logic emu0_i,
    input wire logic off_n_i,
    input wire logic port_bus_holder_en_i,
    input wire logic timer1_out_i,
    input wire logic host_reg_select_lo_i,
    input wire logic host_reg_select_hi_i,
    input wire logic byte_order_flag_i,
    input wire logic port_select_n_i,
    input wire logic host_strobe_a_n_i,
    input wire logic host_strobe_b_n_i,
    input wire logic host_addr_strobe_n_i,
    input wire logic host_direction_i,
    input wire logic [7:0] host_byte_bus_i,
    output logic [7:0] host_byte_bus_o,
    output logic [7:0] host_byte_bus_oe_o,
    output logic host_byte_bus_hold_o,
    input wire logic [7:0] gpio_out_i,
    input wire logic [7:0] gpio_dir_i,
    input wire logic [ADDR_W-1:0] wide_address_bus_i,
    input wire logic [DATA_W-1:0] wide_data_bus_i,
    output logic [DATA_W-1:0] wide_data_bus_o,
    output logic wide_data_bus_oe_o,
    output logic port_ready_out_o,
    output logic port_ready_out_oe_o,
    output logic host_irq_out_o,
    output logic host_irq_out_oe_o,
    output logic control_pullup_en_o,
    output logic select_pullup_en_o,
    output logic port_enabled_o,
    output logic dev_irq_o,
    input wire logic host_irq_set_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [DATA_W-1:0] mem_rdata_i
);
    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    logic rst_d_r;
    logic rst_d_nxt;
    logic en_r;
    logic en_nxt;
    logic wide;
    logic off_cond;

    assign wide = wide_mode_strap_i;
    assign off_cond = ~test_reset_i & emu0_i & ~off_n_i;

    always_comb begin
        rst_d_nxt = rst_n_i;
        en_nxt = en_r;
        // sample only on the cycle after release; later strap changes are ignored
        if (rst_n_i && !rst_d_r) begin
            en_nxt = port_enable_strap_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rst_d_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            rst_d_r <= rst_d_nxt;
            en_r <= en_nxt;
        end
    end

    assign port_enabled_o = en_r;
    assign control_pullup_en_o = ~port_enable_strap_i;
    assign select_pullup_en_o = ~port_enable_strap_i | wide;

    // ----------------------------------------------------------------
    // strobe detection
    // ----------------------------------------------------------------
    logic stb_start;
    logic stb_end;
    logic [1:0] sel;

    hpif_strobe u_strobe (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .port_select_n_i(port_select_n_i),
        .host_strobe_a_n_i(host_strobe_a_n_i),
        .host_strobe_b_n_i(host_strobe_b_n_i),
        .strobe_start_o(stb_start),
        .strobe_end_o(stb_end)
    );

    assign sel = {host_reg_select_hi_i, host_reg_select_lo_i};

    // ----------------------------------------------------------------
    // access engine
    // ----------------------------------------------------------------
    hpif_state_t st_r;
    hpif_state_t st_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [DATA_W-1:0] wbuf_r;
    logic [DATA_W-1:0] wbuf_nxt;
    logic [DATA_W-1:0] rbuf_r;
    logic [DATA_W-1:0] rbuf_nxt;
    logic we_r;
    logic we_nxt;
    logic inc_r;
    logic inc_nxt;
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;
    logic drive_r;
    logic drive_nxt;
    logic astb_d_r;
    logic astb_fall;
    logic go;

    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic second);
        pick_byte = second ? w[7:0] : w[15:8];
    endfunction

    assign astb_fall = ~host_addr_strobe_n_i & astb_d_r & ~port_select_n_i;
    assign go = en_r & stb_start & (st_r == HPIF_IDLE);

    always_comb begin
        st_nxt = st_r;
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r;
        wbuf_nxt = wbuf_r;
        rbuf_nxt = rbuf_r;
        we_nxt = we_r;
        inc_nxt = inc_r;
        dout_nxt = dout_r;
        drive_nxt = drive_r;
        if (host_irq_set_i) begin
            ctrl_nxt[`HPIF_CTRL_HOSTIRQ_BIT] = 1'b1;
        end
        // address latch from the multiplexed byte bus
        if (!wide && en_r && astb_fall) begin
            addr_nxt = byte_order_flag_i ? {addr_r[15:8], host_byte_bus_i}
                                         : {host_byte_bus_i, addr_r[7:0]};
        end
        if (stb_end) begin
            drive_nxt = 1'b0;
        end
        case (st_r)
            HPIF_IDLE: begin
                if (go && wide) begin
                    // wide mode: no control/address regs, address from pins
                    addr_nxt = wide_address_bus_i;
                    we_nxt = ~host_direction_i;
                    drive_nxt = host_direction_i;
                    wbuf_nxt = wide_data_bus_i;
                    inc_nxt = 1'b0;
                    st_nxt = HPIF_MEM;
                end else if (go && host_direction_i) begin
                    drive_nxt = 1'b1;
                    case (sel)
                        `HPIF_SEL_CTRL: dout_nxt = pick_byte(ctrl_r, byte_order_flag_i);
                        `HPIF_SEL_ADDR: dout_nxt = pick_byte(addr_r, byte_order_flag_i);
                        default: begin
                            dout_nxt = pick_byte(rbuf_r, byte_order_flag_i);
                            if (!byte_order_flag_i) begin
                                we_nxt = 1'b0;
                                inc_nxt = 1'b0;
                                st_nxt = HPIF_MEM;
                            end else if (sel == `HPIF_SEL_DATA_INC) begin
                                addr_nxt = addr_r + 16'h0001;
                            end
                        end
                    endcase
                end else if (go) begin
                    case (sel)
                        `HPIF_SEL_CTRL: begin
                            if (byte_order_flag_i) begin
                                // writing 1 clears host irq, a new set wins
                                if (host_byte_bus_i[`HPIF_CTRL_HOSTIRQ_BIT]
                                    && !host_irq_set_i) begin
                                    ctrl_nxt[`HPIF_CTRL_HOSTIRQ_BIT] = 1'b0;
                                end
                                ctrl_nxt[`HPIF_CTRL_DEVIRQ_BIT] =
                                    host_byte_bus_i[`HPIF_CTRL_DEVIRQ_BIT];
                            end
                        end
                        `HPIF_SEL_ADDR: begin
                            addr_nxt = byte_order_flag_i ? {addr_r[15:8], host_byte_bus_i}
                                                         : {host_byte_bus_i, addr_r[7:0]};
                        end
                        default: begin
                            if (!byte_order_flag_i) begin
                                wbuf_nxt = {host_byte_bus_i, wbuf_r[7:0]};
                            end else begin
                                wbuf_nxt = {wbuf_r[15:8], host_byte_bus_i};
                                we_nxt = 1'b1;
                                inc_nxt = (sel == `HPIF_SEL_DATA_INC);
                                st_nxt = HPIF_MEM;
                            end
                        end
                    endcase
                end
            end
            HPIF_MEM: begin
                if (mem_ack_i) begin
                    if (!we_r) begin
                        rbuf_nxt = mem_rdata_i;
                        dout_nxt = rbuf_nxt[15:8];
                    end
                    if (inc_r) begin
                        addr_nxt = addr_r + 16'h0001;
                    end
                    st_nxt = HPIF_DONE;
                end
            end
            HPIF_DONE: begin
                st_nxt = HPIF_IDLE;
            end
            default: begin
                st_nxt = HPIF_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= HPIF_IDLE;
            ctrl_r <= `HPIF_CTRL_RST;
            addr_r <= `HPIF_ADDR_RST;
            wbuf_r <= '0;
            rbuf_r <= '0;
            we_r <= 1'b0;
            inc_r <= 1'b0;
            dout_r <= 8'h00;
            drive_r <= 1'b0;
            astb_d_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            wbuf_r <= wbuf_nxt;
            rbuf_r <= rbuf_nxt;
            we_r <= we_nxt;
            inc_r <= inc_nxt;
            dout_r <= dout_nxt;
            drive_r <= drive_nxt;
            astb_d_r <= host_addr_strobe_n_i;
        end
    end

    // ----------------------------------------------------------------
    // memory side
    // ----------------------------------------------------------------
    assign mem_req_o = (st_r == HPIF_MEM);
    assign mem_we_o = we_r;
    assign mem_addr_o = addr_r;
    assign mem_wdata_o = wbuf_r;
    assign dev_irq_o = ctrl_r[`HPIF_CTRL_DEVIRQ_BIT] & ~wide;

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    always_comb begin
        host_byte_bus_o = dout_r;
        host_byte_bus_oe_o = 8'h00;
        if (off_cond) begin
            host_byte_bus_oe_o = 8'h00;
        end else if (wide) begin
            host_byte_bus_o = gpio_out_i;
            host_byte_bus_oe_o = gpio_dir_i;
        end else if (drive_r && en_r) begin
            host_byte_bus_oe_o = 8'hFF;
        end
    end

    // holders off through reset since the enable input is gated by it
    assign host_byte_bus_hold_o = rst_n_i & port_bus_holder_en_i;

    assign wide_data_bus_o = rbuf_r;
    assign wide_data_bus_oe_o = wide & en_r & drive_r & ~off_cond;

    // ready: low while a word access is outstanding
    assign port_ready_out_o = (st_r == HPIF_IDLE) & rst_n_i;
    assign port_ready_out_oe_o = ~off_cond & en_r;

    always_comb begin
        host_irq_out_o = `HPIF_IRQ_RST;
        if (!rst_n_i) begin
            host_irq_out_o = `HPIF_IRQ_RST;
        end else if (!en_r) begin
            host_irq_out_o = timer1_out_i;
        end else begin
            host_irq_out_o = ~ctrl_r[`HPIF_CTRL_HOSTIRQ_BIT];
        end
    end
    assign host_irq_out_oe_o = ~off_cond & (~rst_n_i | ~en_r | ~wide);
endmodule

// File: tb/hpif_port_properties.sv
// checker of the host port pin behaviour
module hpif_port_properties #(parameter int ADDR_W = 16) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wide_mode_strap_i,
    input wire logic test_reset_i,
    input wire logic emu0_i,
    input wire logic off_n_i,
    input wire logic timer1_out_i,
    input wire logic [7:0] host_byte_bus_oe_o,
    input wire logic port_ready_out_o,
    input wire logic port_ready_out_oe_o,
    input wire logic host_irq_out_o,
    input wire logic host_irq_out_oe_o,
    input wire logic wide_data_bus_oe_o,
    input wire logic control_pullup_en_o,
    input wire logic port_enabled_o,
    input wire logic mem_req_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_ack_i
);
    logic off;
    assign off = !test_reset_i && emu0_i && !off_n_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // two settled cycles of reset before the pin is judged
    a_reset_irq_high: assert property (disable iff (1'b0) !rst_n_i && $past(!rst_n_i)
        && $past(!rst_n_i, 2) |-> host_irq_out_o && host_irq_out_oe_o)
        else $error("interrupt pin not driven high in reset");
    a_off_floats: assert property (off && $past(off) |-> !port_ready_out_oe_o
        && !host_irq_out_oe_o && !wide_data_bus_oe_o && host_byte_bus_oe_o == 8'h00)
        else $error("driver enabled under output disable");
    a_wide_no_irq: assert property (wide_mode_strap_i && $past(wide_mode_strap_i)
        && $past(rst_n_i) |-> !host_irq_out_oe_o)
        else $error("interrupt pin driven in wide mode");
    a_disabled_no_ready: assert property (!port_enabled_o && $past(!port_enabled_o)
        && $past(rst_n_i) |-> !port_ready_out_oe_o)
        else $error("ready driven while port disabled");
    a_timer_on_irq: assert property (!port_enabled_o && $past(!port_enabled_o) && !off
        && $past(!off) && !wide_mode_strap_i && $past(!wide_mode_strap_i)
        && $stable(timer1_out_i) && $past(rst_n_i) |-> host_irq_out_o == timer1_out_i)
        else $error("timer output missing on interrupt pin");
    a_pullup_off: assert property (port_enabled_o && $past(port_enabled_o)
        |-> !control_pullup_en_o)
        else $error("control pullups on with port enabled");
    a_enable_sticky: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
        && !port_enabled_o |=> !port_enabled_o)
        else $error("disabled port came alive without reset");
    a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o))
        else $error("word request dropped before answer");
    a_ready_busy: assert property (mem_req_o || $past(mem_ack_i) |-> !port_ready_out_o)
        else $error("ready high during word access");
    c_word: cover property (mem_req_o && mem_ack_i);
    c_off: cover property (off ##1 off);
    c_disabled: cover property (!port_enabled_o ##1 !port_enabled_o);
endmodule

bind hpif_port hpif_port_properties #(.ADDR_W(ADDR_W)) u_props (.*);

// File: tb/hpif_mem_model.sv
// memory side responder for the host port bench
module hpif_mem_model (
    input wire logic ref_clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic [3:0] lat_i,
    output logic mem_ack_o = 1'b0,
    output logic [15:0] mem_rdata_o = 16'h0000,
    output logic [15:0] last_addr_o = 16'h0000,
    output logic [15:0] last_wdata_o = 16'h0000,
    output logic last_we_o = 1'b0,
    output logic [7:0] n_req_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r = 4'h0;
    logic busy_r = 1'b0;
    // read data flips every cycle outside the answer, so a late sample shows up
    always @(posedge ref_clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!mem_req_i) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (!busy_r) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r >= lat_i) begin
                mem_ack_o <= 1'b1;
                busy_r <= 1'b1;
                mem_rdata_o <= mem_addr_i ^ 16'hA5C3;
                last_addr_o <= mem_addr_i;
                last_wdata_o <= mem_wdata_i;
                last_we_o <= mem_we_i;
                n_req_o <= n_req_o + 8'h01;
            end
        end
    end
endmodule

// File: tb/hpif_port_tb.sv
// self-checking bench of the parallel host port
`include "hpif_cfg.svh"
module hpif_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_n_i = 0, port_enable_strap_i = 1, wide_mode_strap_i = 0;
    logic test_reset_i = 1, emu0_i = 0, off_n_i = 1, port_bus_holder_en_i = 0;
    logic timer1_out_i = 0, host_reg_select_lo_i = 0, host_reg_select_hi_i = 0;
    logic byte_order_flag_i = 0, port_select_n_i = 1, host_strobe_a_n_i = 1;
    logic host_strobe_b_n_i = 1, host_addr_strobe_n_i = 1, host_direction_i = 0;
    logic host_irq_set_i = 0, mem_ack_i, mem_we_o, mem_req_o, l_we;
    logic [7:0] hb_drv = 0, gpio_out_i = 0, gpio_dir_i = 0, host_byte_bus_i, nr, n_req;
    logic [7:0] host_byte_bus_o, host_byte_bus_oe_o;
    logic [15:0] wide_address_bus_i = 0, wide_data_bus_i = 0, wide_data_bus_o, a, w, v;
    logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, l_addr, l_wdata;
    logic host_byte_bus_hold_o, wide_data_bus_oe_o, port_ready_out_o, port_ready_out_oe_o;
    logic host_irq_out_o, host_irq_out_oe_o, control_pullup_en_o, select_pullup_en_o;
    logic port_enabled_o, dev_irq_o;
    logic [3:0] lat = 0;
    logic [31:0] seed = 32'hA1AC26D7;
    int n_mismatch = 0, compares = 0;
    // each byte pin shows whoever enables it
    assign host_byte_bus_i = (host_byte_bus_oe_o & host_byte_bus_o)
        | (~host_byte_bus_oe_o & hb_drv);
    hpif_port u_dut (.*);
    hpif_mem_model u_mem (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .lat_i(lat), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i), .last_addr_o(l_addr), .last_wdata_o(l_wdata),
        .last_we_o(l_we), .n_req_o(n_req));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // bounded wait; the host may not start before ready
    task automatic wait_rdy();
        int k;
        k = 0;
        while (port_ready_out_o !== 1'b1 && k < 100) begin
            @(posedge ref_clk_i);
            k++;
        end
        if (k == 100) n_mismatch++;
    endtask
    task automatic acc(input logic [1:0] s, input logic f, input logic d, input logic [7:0] b,
        output logic [7:0] q);
        @(posedge ref_clk_i);
        wait_rdy();
        {host_reg_select_hi_i, host_reg_select_lo_i} <= s;
        byte_order_flag_i <= f;
        host_direction_i <= d;
        hb_drv <= d ? ~b : b;
        port_select_n_i <= 1'b0;
        host_strobe_a_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        wait_rdy();
        @(posedge ref_clk_i);
        q = host_byte_bus_o;
        host_strobe_a_n_i <= 1'b1;
        port_select_n_i <= 1'b1;
    endtask
    task automatic wr16(input logic [1:0] s, input logic [15:0] x);
        logic [7:0] q;
        acc(s, 1'b0, 1'b0, x[15:8], q);
        acc(s, 1'b1, 1'b0, x[7:0], q);
    endtask
    task automatic rd16(input logic [1:0] s, output logic [15:0] x);
        acc(s, 1'b0, 1'b1, w[7:0], x[15:8]);
        acc(s, 1'b1, 1'b1, w[15:8], x[7:0]);
    endtask
    task automatic reset(input logic en, input logic wide);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        port_enable_strap_i <= en;
        wide_mode_strap_i <= wide;
        repeat (5) @(posedge ref_clk_i);
        chk(host_irq_out_o, 1'b1, "irq in reset");
        chk(host_byte_bus_hold_o, 1'b0, "holder in reset");
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk(port_enabled_o, en, "port enabled");
    endtask
    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        reset(1'b1, 1'b0);
        for (int i = 0; i < 6; i++) begin
            {w, a} = xs();
            lat <= w[3:0];
            if (i == 0) a = 16'hFFFF;
            wr16(`HPIF_SEL_ADDR, a);
            wr16(`HPIF_SEL_DATA_INC, w);
            chk(l_addr, a, "write address");
            chk({l_we, l_wdata}, {1'b1, w}, "write word");
            rd16(`HPIF_SEL_DATA, v);
            chk(l_addr, a + 16'h1, "inc address");
            chk(v, (a + 16'h1) ^ 16'hA5C3, "read word");
            rd16(`HPIF_SEL_DATA_INC, v);
            rd16(`HPIF_SEL_DATA, v);
            chk(l_addr, a + 16'h2, "read inc address");
        end
        $display("test transfers done");
        @(posedge ref_clk_i);
        port_select_n_i <= 1'b0;
        host_addr_strobe_n_i <= 1'b0;
        byte_order_flag_i <= 1'b0;
        hb_drv <= a[15:8];
        @(posedge ref_clk_i);
        host_addr_strobe_n_i <= 1'b1;
        byte_order_flag_i <= 1'b1;
        hb_drv <= a[7:0];
        @(posedge ref_clk_i);
        host_addr_strobe_n_i <= 1'b0;
        @(posedge ref_clk_i);
        host_addr_strobe_n_i <= 1'b1;
        port_select_n_i <= 1'b1;
        rd16(`HPIF_SEL_DATA, v);
        chk(l_addr, a, "strobed address");
        @(posedge ref_clk_i);
        host_irq_set_i <= 1'b1;
        @(posedge ref_clk_i);
        host_irq_set_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(host_irq_out_o, 1'b0, "host irq set");
        acc(`HPIF_SEL_CTRL, 1'b1, 1'b0, 8'h0C, nr);
        chk(host_irq_out_o, 1'b1, "host irq cleared");
        chk(dev_irq_o, 1'b1, "device irq");
        $display("test strobe and irq done");
        @(posedge ref_clk_i);
        nr = n_req;
        byte_order_flag_i <= 1'b0;
        host_direction_i <= 1'b1;
        host_strobe_a_n_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        chk(host_byte_bus_oe_o, 8'h00, "bus float unselected");
        host_strobe_a_n_i <= 1'b1;
        chk(n_req, nr, "strobe without select");
        $display("test select done");
        test_reset_i <= 1'b0;
        emu0_i <= 1'b1;
        off_n_i <= 1'b0;
        port_bus_holder_en_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk({port_ready_out_oe_o, host_irq_out_oe_o, wide_data_bus_oe_o, host_byte_bus_oe_o},
            11'h000, "off enables");
        chk(host_byte_bus_hold_o, 1'b1, "holder on");
        test_reset_i <= 1'b1;
        $display("test off done");
        reset(1'b0, 1'b0);
        port_enable_strap_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            timer1_out_i <= w[i];
            repeat (3) @(posedge ref_clk_i);
            chk(host_irq_out_o, w[i], "timer on irq");
        end
        chk(port_enabled_o, 1'b0, "stays disabled");
        $display("test disabled done");
        reset(1'b1, 1'b1);
        repeat (2) @(posedge ref_clk_i);
        chk(host_irq_out_oe_o, 1'b0, "wide irq");
        wide_address_bus_i <= a;
        wide_data_bus_i <= w;
        acc(`HPIF_SEL_DATA, 1'b0, 1'b0, 8'h00, nr);
        chk(l_addr, a, "wide address");
        chk({l_we, l_wdata}, {1'b1, w}, "wide write");
        acc(`HPIF_SEL_DATA, 1'b0, 1'b1, 8'h00, nr);
        chk(wide_data_bus_oe_o, 1'b1, "wide drive");
        chk(wide_data_bus_o, a ^ 16'hA5C3, "wide read");
        @(posedge ref_clk_i);
        gpio_dir_i <= 8'hFF;
        gpio_out_i <= w[7:0];
        repeat (2) @(posedge ref_clk_i);
        chk({host_byte_bus_oe_o, host_byte_bus_o}, {8'hFF, w[7:0]}, "gpio pins");
        $display("test wide done");
        conclude();
    end
endmodule
